/* File: pkg/fdc_pins_pkg.sv */
// constants for the floppy drive pin interface block
package fdc_pins_pkg;
   // register byte offsets on the APB bus
   localparam logic [7:0] OFS_DOUT = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STEP = 8'h08;
   localparam logic [7:0] OFS_WDAT = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_DIN = 8'h14;
   localparam logic [7:0] OFS_FLUX = 8'h18;
   // digital output register fields
   localparam int DOUT_MOTOR_LSB = 0;
   localparam int DOUT_UNIT_LSB = 4;
   localparam int DOUT_DMAEN_BIT = 6;
   localparam logic [7:0] DOUT_RESET = 8'h00;
   // control register fields
   localparam int CTRL_RATE_LSB = 0;
   localparam int CTRL_ALT_BIT = 2;
   localparam int CTRL_SIDE_BIT = 3;
   localparam int CTRL_WGATE_BIT = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // step register fields: count in 7:0, outward direction in bit 8
   localparam int STEP_DIR_BIT = 8;
   // status register fields
   localparam int ST_WPROT = 0;
   localparam int ST_TRK0 = 1;
   localparam int ST_INDEX = 2;
   localparam int ST_TWO = 3;
   localparam int ST_COMPAT = 4;
   localparam int ST_STEPBSY = 5;
   localparam int ST_WRBSY = 6;
   localparam int ST_WDEMPTY = 7;
   localparam int DIN_CHANGE_BIT = 7;
   // source edges per bit cell
   localparam logic [7:0] CRYSTAL_OSC_DRIVE_DIV_500K = 8'h20;
   localparam logic [7:0] CRYSTAL_OSC_DRIVE_DIV_250K = 8'h40;
   localparam logic [7:0] CRYSTAL_OSC_DRIVE_DIV_125K = 8'h80;
   localparam logic [7:0] ALT_DIV = 8'h20;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int STEP_PULSE_NS = 1000;
   localparam int STEP_RATE_US = 3000;
   localparam int WPULSE_NS = 100;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_RATE_CYC = STEP_RATE_US * CLK_MHZ;
   localparam int WPULSE_CYC = (WPULSE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_PULSE = 3'b010,
      S_GAP = 3'b100
   } step_state_e;
   typedef enum logic [2:0] {
      W_IDLE = 3'b001,
      W_LEAD = 3'b010,
      W_SHIFT = 3'b100
   } wr_state_e;
endpackage

/* File: rtl/fdc_drive_pins.sv */
// drive-side pin logic with APB register access
`timescale 1ns/100ps
module fdc_drive_pins
   import fdc_pins_pkg::*;
#(
   parameter int STEP_RATE_CYCLES = STEP_RATE_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic alt_rate_clock,
   input wire logic crystal_osc_in,
   output logic crystal_osc_drive,
   input wire logic host_compat_select,
   input wire logic drive_class_select,
   input wire logic disk_read_pulses_n,
   input wire logic media_changed_n,
   input wire logic write_protect_n,
   input wire logic outer_track_n,
   input wire logic index_mark_n,
   input wire logic second_unit_present_n,
   output logic spindle_on0_n,
   output logic spindle_on1_n,
   output logic spindle_on2_n,
   output logic unit_select0_n,
   output logic unit_select1_n,
   output logic unit_select2_n,
   output logic side_select_n,
   output logic write_gate_n,
   output logic write_pulses_n,
   output logic step_pulse_n,
   output logic step_dir_n,
   output logic density_select_n,
   output logic dma_qualify
);
   // synchronisers: stage a feeds only stage b
   logic [7:0] syncA_ff;
   logic [7:0] syncB_ff;
   logic [1:0] histB_ff;
   logic [7:0] dout_ff;
   logic [7:0] ctrl_ff;
   logic [7:0] wdat_ff;
   logic wdFull_ff;
   logic [15:0] flux_ff;
   logic [7:0] srcDiv_ff;
   logic bitTick_ff;
   step_state_e stepSt_ff;
   logic [7:0] stepLeft_ff;
   logic stepDir_ff;
   logic [31:0] stepCnt_ff;
   wr_state_e wrSt_ff;
   logic [7:0] shift_ff;
   logic [3:0] bitsLeft_ff;
   logic [7:0] wpCnt_ff;
   logic [31:0] nxt_prdata;

   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic wrAcc = access & pwrite;
   wire logic hitDout = paddr == OFS_DOUT;
   wire logic hitCtrl = paddr == OFS_CTRL;
   wire logic hitStep = paddr == OFS_STEP;
   wire logic hitWdat = paddr == OFS_WDAT;
   wire logic hitStat = paddr == OFS_STAT;
   wire logic hitDin = paddr == OFS_DIN;
   wire logic hitFlux = paddr == OFS_FLUX;
   wire logic mapped = hitDout | hitCtrl | hitStep | hitWdat | hitStat | hitDin | hitFlux;

   wire logic [1:0] rate = ctrl_ff[CTRL_RATE_LSB +: 2];
   wire logic altSel = ctrl_ff[CTRL_ALT_BIT];
   wire logic [2:0] motor = dout_ff[DOUT_MOTOR_LSB +: 3];
   wire logic [1:0] unit = dout_ff[DOUT_UNIT_LSB +: 2];

   // synced inputs
   wire logic sCrystal = syncB_ff[0];
   wire logic sAlt = syncB_ff[1];
   wire logic sRead = syncB_ff[2];
   wire logic sChange = syncB_ff[3];
   wire logic sWprot = syncB_ff[4];
   wire logic sTrk0 = syncB_ff[5];
   wire logic sIndex = syncB_ff[6];
   wire logic sTwo = syncB_ff[7];

   // timing source: crystal unless software picks the alternate clock
   wire logic srcLevel = altSel ? sAlt : sCrystal;
   wire logic srcRise = srcLevel & ~histB_ff[0];
   wire logic readFall = histB_ff[1] & ~sRead;

   function automatic logic [7:0] cell_div(input logic alt, input logic [1:0] code);
      logic [7:0] d;
      d = CRYSTAL_OSC_DRIVE_DIV_500K;
      if (alt) begin
         d = ALT_DIV;
      end else begin
         case (code)
            2'h0: d = CRYSTAL_OSC_DRIVE_DIV_500K;
            2'h2: d = CRYSTAL_OSC_DRIVE_DIV_250K;
            2'h3: d = CRYSTAL_OSC_DRIVE_DIV_125K;
            default: d = CRYSTAL_OSC_DRIVE_DIV_250K;
         endcase
      end
      return d;
   endfunction

   wire logic [7:0] cellDiv = cell_div(altSel, rate);

   // write data path
   wire logic wdatWrite = wrAcc & hitWdat;
   wire logic gateOn = ctrl_ff[CTRL_WGATE_BIT];
   wire logic loadByte = bitTick_ff & wdFull_ff & (bitsLeft_ff == 4'h0);
   wire logic bitOne = shift_ff[7];
   wire logic stepWrite = wrAcc & hitStep;

   always_ff @(posedge clock) begin
      if (rst) begin
         syncA_ff <= 8'hFF;
         syncB_ff <= 8'hFF;
         histB_ff <= 2'h3;
      end else begin
         syncA_ff <= {second_unit_present_n, index_mark_n, outer_track_n, write_protect_n,
                      media_changed_n, disk_read_pulses_n, alt_rate_clock,
                      crystal_osc_in};
         syncB_ff <= syncA_ff;
         histB_ff <= {sRead, srcLevel};
      end
   end

   // register writes
   always_ff @(posedge clock) begin
      if (rst) begin
         dout_ff <= DOUT_RESET;
         ctrl_ff <= CTRL_RESET;
      end else begin
         if (wrAcc & hitDout) begin
            dout_ff <= pwdata[7:0];
         end
         if (wrAcc & hitCtrl) begin
            ctrl_ff <= pwdata[7:0];
         end
      end
   end

   // flux counter
   always_ff @(posedge clock) begin
      if (rst) begin
         flux_ff <= 16'h0000;
      end else if (setup & ~pwrite & hitFlux) begin
         // cleared as its value is captured, so no edge is lost between capture and clear
         flux_ff <= {15'h0000, readFall};
      end else if (readFall) begin
         flux_ff <= flux_ff + 16'h0001;
      end
   end

   // bit cell tick from the selected source
   always_ff @(posedge clock) begin
      if (rst) begin
         srcDiv_ff <= 8'h00;
         bitTick_ff <= 1'b0;
      end else begin
         bitTick_ff <= 1'b0;
         if (srcRise) begin
            if (srcDiv_ff >= cellDiv - 8'h01) begin
               srcDiv_ff <= 8'h00;
               bitTick_ff <= 1'b1;
            end else begin
               srcDiv_ff <= srcDiv_ff + 8'h01;
            end
         end
      end
   end

   // step sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         stepSt_ff <= S_IDLE;
         stepLeft_ff <= 8'h00;
         stepDir_ff <= 1'b0;
         stepCnt_ff <= 32'h0;
      end else begin
         case (stepSt_ff)
            S_IDLE: begin
               if (stepWrite && pwdata[7:0] != 8'h00) begin
                  stepLeft_ff <= pwdata[7:0];
                  stepDir_ff <= pwdata[STEP_DIR_BIT];
                  stepCnt_ff <= 32'h0;
                  stepSt_ff <= S_PULSE;
               end
            end
            S_PULSE: begin
               if (stepCnt_ff >= 32'(STEP_PULSE_CYC - 1)) begin
                  stepCnt_ff <= 32'h0;
                  stepLeft_ff <= stepLeft_ff - 8'h01;
                  stepSt_ff <= S_GAP;
               end else begin
                  stepCnt_ff <= stepCnt_ff + 32'h1;
               end
            end
            S_GAP: begin
               if (stepCnt_ff >= 32'(STEP_RATE_CYCLES - STEP_PULSE_CYC - 1)) begin
                  stepCnt_ff <= 32'h0;
                  stepSt_ff <= (stepLeft_ff == 8'h00) ? S_IDLE : S_PULSE;
               end else begin
                  stepCnt_ff <= stepCnt_ff + 32'h1;
               end
            end
            default: stepSt_ff <= S_IDLE;
         endcase
      end
   end

   // write serialiser
   always_ff @(posedge clock) begin
      if (rst) begin
         wrSt_ff <= W_IDLE;
         wdat_ff <= 8'h00;
         wdFull_ff <= 1'b0;
         shift_ff <= 8'h00;
         bitsLeft_ff <= 4'h0;
         wpCnt_ff <= 8'h00;
      end else begin
         if (wdatWrite & ~wdFull_ff) begin
            wdat_ff <= pwdata[7:0];
            wdFull_ff <= 1'b1;
         end else if (loadByte & (wrSt_ff == W_SHIFT)) begin
            wdFull_ff <= 1'b0;
         end
         if (wpCnt_ff != 8'h00) begin
            wpCnt_ff <= wpCnt_ff - 8'h01;
         end
         case (wrSt_ff)
            W_IDLE: begin
               bitsLeft_ff <= 4'h0;
               if (gateOn & wdFull_ff) begin
                  wrSt_ff <= W_LEAD;
               end
            end
            W_LEAD: begin
               if (~gateOn) begin
                  wrSt_ff <= W_IDLE;
               end else if (bitTick_ff) begin
                  wrSt_ff <= W_SHIFT;
               end
            end
            W_SHIFT: begin
               if (~gateOn) begin
                  wrSt_ff <= W_IDLE;
               end else if (bitTick_ff) begin
                  if (bitsLeft_ff != 4'h0) begin
                     if (bitOne) begin
                        wpCnt_ff <= 8'(WPULSE_CYC);
                     end
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     bitsLeft_ff <= bitsLeft_ff - 4'h1;
                  end else if (wdFull_ff) begin
                     shift_ff <= wdat_ff;
                     bitsLeft_ff <= 4'h8;
                  end
               end
            end
            default: wrSt_ff <= W_IDLE;
         endcase
      end
   end

   // read mux
   always_comb begin
      nxt_prdata = 32'h0;
      if (hitDout) begin
         nxt_prdata[7:0] = dout_ff;
      end else if (hitCtrl) begin
         nxt_prdata[7:0] = ctrl_ff;
      end else if (hitStep) begin
         nxt_prdata[7:0] = stepLeft_ff;
         nxt_prdata[STEP_DIR_BIT] = stepDir_ff;
      end else if (hitWdat) begin
         nxt_prdata[7:0] = wdat_ff;
      end else if (hitStat) begin
         nxt_prdata[ST_WPROT] = ~sWprot;
         nxt_prdata[ST_TRK0] = ~sTrk0;
         nxt_prdata[ST_INDEX] = ~sIndex;
         nxt_prdata[ST_TWO] = ~sTwo;
         nxt_prdata[ST_COMPAT] = host_compat_select;
         nxt_prdata[ST_STEPBSY] = stepSt_ff != S_IDLE;
         nxt_prdata[ST_WRBSY] = wrSt_ff != W_IDLE;
         nxt_prdata[ST_WDEMPTY] = ~wdFull_ff;
      end else if (hitDin) begin
         nxt_prdata[DIN_CHANGE_BIT] = ~sChange;
      end else if (hitFlux) begin
         nxt_prdata[15:0] = flux_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (setup & ~pwrite) begin
         prdata <= nxt_prdata;
      end
   end

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // drive pins
   assign crystal_osc_drive = ~crystal_osc_in;
   assign spindle_on0_n = ~motor[0];
   assign spindle_on1_n = ~motor[1];
   assign spindle_on2_n = ~motor[2];
   assign unit_select0_n = ~(motor[0] & (unit == 2'h0));
   assign unit_select1_n = ~(motor[1] & (unit == 2'h1));
   assign unit_select2_n = ~(motor[2] & (unit == 2'h2));
   assign side_select_n = ~ctrl_ff[CTRL_SIDE_BIT];
   assign write_gate_n = (wrSt_ff == W_IDLE);
   assign write_pulses_n = (wpCnt_ff == 8'h00);
   assign step_pulse_n = (stepSt_ff != S_PULSE);
   assign step_dir_n = stepDir_ff;
   assign density_select_n = drive_class_select ? rate[1] : ~rate[0];
   assign dma_qualify = host_compat_select ? dout_ff[DOUT_DMAEN_BIT] : 1'b1;
endmodule

/* File: test/fdc_pins_props.sv */
// port assertions for the floppy drive pin block
`timescale 1ns/100ps
module fdc_pins_props
   import fdc_pins_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic host_compat_select,
   input wire logic drive_class_select,
   input wire logic spindle_on0_n,
   input wire logic spindle_on1_n,
   input wire logic spindle_on2_n,
   input wire logic unit_select0_n,
   input wire logic unit_select1_n,
   input wire logic unit_select2_n,
   input wire logic side_select_n,
   input wire logic write_gate_n,
   input wire logic write_pulses_n,
   input wire logic step_pulse_n,
   input wire logic step_dir_n,
   input wire logic density_select_n,
   input wire logic dma_qualify
);
   int lowCnt_ff;
   // counts the cycles of the current step pulse
   always_ff @(posedge clock) begin
      if (rst || step_pulse_n) lowCnt_ff <= 0;
      else lowCnt_ff <= lowCnt_ff + 1;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence wrAt(logic [7:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence
   sequence pulseLow20;
      (!write_pulses_n)[*8] ##12 !write_pulses_n ##1 write_pulses_n;
   endsequence
   spin_follow_a: assert property (wrAt(OFS_DOUT) |=>
      {spindle_on2_n, spindle_on1_n, spindle_on0_n} == ~$past(pwdata[2:0]))
      else $error("motor enables differ from written bits");
   unit_code_a: assert property (wrAt(OFS_DOUT) |=>
      {unit_select2_n, unit_select1_n, unit_select0_n} ==
      ~($past(pwdata[2:0]) & (3'h1 << $past(pwdata[5:4]))))
      else $error("unit selects differ from written code");
   unit_qual_a: assert property ((unit_select0_n || !spindle_on0_n) &&
      (unit_select1_n || !spindle_on1_n) && (unit_select2_n || !spindle_on2_n))
      else $error("unit selected without its motor");
   side_sel_a: assert property (wrAt(OFS_CTRL) |=>
      side_select_n == !$past(pwdata[3])) else $error("side select wrong");
   density_a: assert property (wrAt(OFS_CTRL) |=> density_select_n ==
      (drive_class_select ? $past(pwdata[1]) : !$past(pwdata[0])))
      else $error("density select wrong");
   step_width_a: assert property ($rose(step_pulse_n) |-> lowCnt_ff == 200)
      else $error("step pulse width wrong");
   dir_hold_a: assert property (!step_pulse_n && !$past(step_pulse_n) |->
      $stable(step_dir_n)) else $error("direction moved during step");
   gate_lead_a: assert property ($fell(write_pulses_n) |->
      !write_gate_n && !$past(write_gate_n)) else $error("pulse without gate");
   wpulse_width_a: assert property ($fell(write_pulses_n) |-> pulseLow20)
      else $error("write pulse width wrong");
   dma_qual_a: assert property (!host_compat_select |-> dma_qualify)
      else $error("dma qualify low in plain mode");
   reset_out_a: assert property (disable iff (1'b0) rst |=> spindle_on0_n &&
      spindle_on1_n && spindle_on2_n && unit_select0_n && unit_select1_n &&
      unit_select2_n && write_gate_n && write_pulses_n && step_pulse_n)
      else $error("outputs active after reset");
endmodule

/* File: test/fdc_drive_model.sv */
// behavioural drive mechanism on the far side of the pin block
`timescale 1ns/100ps
module fdc_drive_model #(
   parameter int START_TRACK = 3,
   parameter int INDEX_PERIOD = 300
) (
   input wire logic clock,
   input wire logic step_pulse_n,
   input wire logic step_dir_n,
   input wire logic write_gate_n,
   input wire logic write_pulses_n,
   input wire logic wpSet,
   output logic outer_track_n,
   output logic index_mark_n,
   output logic write_protect_n,
   output logic disk_read_pulses_n
);
   int track_ff = START_TRACK;
   int idx_ff = 0;
   logic lastStep_ff = 1'b1;
   // head moves at the trailing edge, by the direction level seen there
   always @(posedge step_pulse_n) begin
      if (lastStep_ff === 1'b0) begin
         if (step_dir_n) track_ff <= (track_ff > 0) ? track_ff - 1 : 0;
         else track_ff <= track_ff + 1;
      end
   end
   always @(posedge clock) begin
      lastStep_ff <= step_pulse_n;
      idx_ff <= (idx_ff == INDEX_PERIOD - 1) ? 0 : idx_ff + 1;
   end
   assign outer_track_n = (track_ff != 0);
   assign index_mark_n = (idx_ff >= 8);
   assign write_protect_n = !wpSet;
   // read head returns what the write head lays down, idle high
   assign disk_read_pulses_n = write_gate_n | write_pulses_n;
endmodule

/* File: test/fdc_drive_pins_tb.sv */
// self-checking bench for the floppy drive pin block
`timescale 1ns/100ps
module fdc_drive_pins_tb;
   import fdc_pins_pkg::*;
   logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, b;
   logic [31:0] pwdata = 32'h0, prdata, rd, e, o;
   logic [2:0] m;
   logic alt_rate_clock = 1'b0, crystal_osc_in = 1'b0, host_compat_select = 1'b1;
   logic drive_class_select = 1'b0, media_changed_n = 1'b1, second_unit_present_n = 1'b1;
   logic wpSet = 1'b0, pready, pslverr, err, crystal_osc_drive, dma_qualify;
   logic density_select_n, step_dir_n, disk_read_pulses_n, write_protect_n;
   logic outer_track_n, index_mark_n, spindle_on0_n, spindle_on1_n, spindle_on2_n;
   logic unit_select0_n, unit_select1_n, unit_select2_n, side_select_n;
   logic write_gate_n, write_pulses_n, step_pulse_n;
   logic [31:0] expQ[$], obsQ[$];
   int n_errors = 0, comparisons = 0, i;
   event seen;
   fdc_drive_pins #(.STEP_RATE_CYCLES(400)) fdc_drive_pins_inst (.*);
   fdc_drive_model fdc_drive_model_inst (.*);
   initial forever #2.5 clock = ~clock;
   always @(posedge clock) crystal_osc_in <= ~crystal_osc_in;
   always @(posedge clock) if (crystal_osc_in) alt_rate_clock <= ~alt_rate_clock;
   always @(seen) begin
      while (obsQ.size() > 0) begin
         e = expQ.pop_front();
         o = obsQ.pop_front();
         comparisons++;
         if (o !== e) begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, o);
         end
      end
   end
   task automatic test_done();
      #1;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      expQ.push_back(x);
      obsQ.push_back(g);
      -> seen;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (k < 20 && pready !== 1'b1);
      if (pready !== 1'b1) begin
         n_errors++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic poll(input logic [7:0] a, input int bitNo, input logic v);
      int k;
      for (k = 0; k < 2000 && !(k > 0 && rd[bitNo] === v); k++) apb(1'b0, a, 32'h0);
      if (k == 2000) n_errors++;
      if (k == 2000) test_done();
   endtask
   task automatic step(input logic outw, input logic [7:0] cnt, input logic trk0);
      apb(1'b1, OFS_STEP, {23'h0, outw, cnt});
      poll(OFS_STAT, ST_STEPBSY, 1'b0);
      repeat (4) @(posedge clock);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(trk0, rd[ST_TRK0]);
      chk(outw, step_dir_n);
   endtask
   // spacing of two back-to-back one bits gives the bit cell length of the chosen source
   task automatic wgap(input logic [7:0] c, input int gap);
      int k, n;
      apb(1'b1, OFS_WDAT, 32'hC0);
      apb(1'b1, OFS_CTRL, {24'h0, c});
      for (k = 0; k < 3000 && write_pulses_n !== 1'b0; k++) @(posedge clock);
      for (n = 0; n < 3000 && write_pulses_n !== 1'b1; n++) @(posedge clock);
      for (; n < 3000 && write_pulses_n !== 1'b0; n++) @(posedge clock);
      if (k == 3000 || n == 3000) begin
         n_errors++;
         test_done();
      end
      chk(gap, n);
      repeat (WPULSE_CYC) @(posedge clock);
      apb(1'b1, OFS_CTRL, 32'h0);
   endtask
   function automatic logic [9:0] pins();
      return {spindle_on0_n, spindle_on1_n, spindle_on2_n, unit_select0_n, unit_select1_n,
         unit_select2_n, side_select_n, write_gate_n, write_pulses_n, step_pulse_n};
   endfunction
   initial begin
      void'($urandom(32'h6567F9C3));
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(11'h7FF, {pins(), density_select_n});
      chk(!crystal_osc_in, crystal_osc_drive);
      for (i = 0; i < 8; i++) begin
         b = 8'($urandom);
         if (b[5:4] == 2'h3) b[5:4] = 2'h2;
         host_compat_select <= i[0];
         apb(1'b1, OFS_DOUT, {24'h0, b});
         @(posedge clock);
         m = ~b[2:0];
         chk(m, {spindle_on2_n, spindle_on1_n, spindle_on0_n});
         m = ~(b[2:0] & (3'h1 << b[5:4]));
         chk(m, {unit_select2_n, unit_select1_n, unit_select0_n});
         chk(i[0] ? b[6] : 1'b1, dma_qualify);
      end
      for (i = 0; i < 8; i++) begin
         drive_class_select <= i[2];
         apb(1'b1, OFS_CTRL, {28'h0, i[0], 1'b0, i[1:0]});
         @(posedge clock);
         chk(i[2] ? i[1] : !i[0], density_select_n);
         chk(!i[0], side_select_n);
      end
      step(1'b1, 8'h02, 1'b0);
      step(1'b1, 8'h01, 1'b1);
      step(1'b0, 8'h01, 1'b0);
      apb(1'b0, OFS_FLUX, 32'h0);
      b = 8'($urandom);
      apb(1'b1, OFS_WDAT, {24'h0, b});
      apb(1'b1, OFS_CTRL, 32'h10);
      poll(OFS_STAT, ST_WDEMPTY, 1'b1);
      chk(1'b0, write_gate_n);
      repeat (552) @(posedge clock);
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_FLUX, 32'h0);
      chk($countones(b), rd);
      wgap(8'h10, 2 * CRYSTAL_OSC_DRIVE_DIV_500K);
      wgap(8'h12, 2 * CRYSTAL_OSC_DRIVE_DIV_250K);
      wgap(8'h13, 2 * CRYSTAL_OSC_DRIVE_DIV_125K);
      wgap(8'h14, 4 * ALT_DIV);
      wpSet <= 1'b1;
      media_changed_n <= 1'b0;
      second_unit_present_n <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1'b0, OFS_STAT, 32'h0);
      chk({27'h0, host_compat_select, 4'h9}, rd & 32'h1B);
      apb(1'b0, OFS_DIN, 32'h0);
      chk(32'h80, rd & 32'h80);
      poll(OFS_STAT, ST_INDEX, 1'b1);
      apb(1'b0, 8'h1C, 32'h0);
      chk(1'b1, err);
      chk(32'h0, rd);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(10'h3FF, pins());
      test_done();
   end
endmodule
bind fdc_drive_pins fdc_pins_props fdc_pins_props_inst (.*);
